/* common/mmd_pkg.sv */
// constants and types shared by the memory map decoder and its snapshot bank
package mmd_pkg;

  // ==========================================================
  // access spaces seen from the core
  typedef enum logic [1:0] {
    MMD_SP_CODE = 2'b00,  // program fetch or constant read
    MMD_SP_XDATA = 2'b01,  // external move instruction access
    MMD_SP_IDATA = 2'b10,  // internal data access
    MMD_SP_RSVD = 2'b11  // never decoded
  } mmd_space_t;

  // ==========================================================
  // decoded target regions
  typedef enum logic [3:0] {
    MMD_RG_NONE = 4'b0000,
    MMD_RG_VECTOR = 4'b0001,
    MMD_RG_FLASH = 4'b0010,
    MMD_RG_CTRLBITS = 4'b0011,
    MMD_RG_EXPANSION_RAM = 4'b0100,
    MMD_RG_EXTENDED_FUNCTION_REGISTERS = 4'b0101,
    MMD_RG_MDU = 4'b0110,
    MMD_RG_CAN = 4'b0111,
    MMD_RG_ADC = 4'b1000,
    MMD_RG_BANK = 4'b1001,
    MMD_RG_INTERNAL_RAM_LO = 4'b1010,
    MMD_RG_INTERNAL_RAM_HI = 4'b1011,
    MMD_RG_SFR = 4'b1100
  } mmd_region_t;

  // ==========================================================
  // program memory windows
  localparam logic [15:0] MMD_CODE_LO = 16'h0000;
  localparam logic [15:0] MMD_CODE_HI = 16'h7fff;
  localparam logic [15:0] MMD_VEC_LO = 16'h0000;
  localparam logic [15:0] MMD_VEC_HI = 16'h00ff;
  localparam logic [15:0] MMD_CTL_LO = 16'h7f00;
  localparam logic [15:0] MMD_CTL_HI = 16'h7fff;

  // ==========================================================
  // external data windows
  localparam logic [15:0] MMD_EXPANSION_RAM_LO = 16'h0000;
  localparam logic [15:0] MMD_EXPANSION_RAM_HI = 16'h0ef7;
  localparam logic [15:0] MMD_EXTENDED_FUNCTION_REGISTERS_LO = 16'h4020;
  localparam logic [15:0] MMD_EXTENDED_FUNCTION_REGISTERS_HI = 16'h40ff;
  localparam logic [15:0] MMD_MDU_LO = 16'h0ef8;
  localparam logic [15:0] MMD_MDU_HI = 16'h0fd7;
  localparam logic [15:0] MMD_CAN_LO = 16'h0eac;
  localparam logic [15:0] MMD_CAN_HI = 16'h0ed7;
  localparam logic [15:0] MMD_ADC_LO = 16'h0fd8;
  localparam logic [15:0] MMD_ADC_HI = 16'h0fff;

  // ==========================================================
  // internal data windows
  localparam logic [15:0] MMD_BANK_LO = 16'h0000;
  localparam logic [15:0] MMD_BANK_HI = 16'h001f;
  localparam logic [15:0] MMD_INTERNAL_RAM_LO = 16'h0020;
  localparam logic [15:0] MMD_INTERNAL_RAM_HI = 16'h007f;
  localparam logic [15:0] MMD_BITRAM_LO = 16'h0020;
  localparam logic [15:0] MMD_BITRAM_HI = 16'h002f;
  localparam logic [15:0] MMD_UPPER_LO = 16'h0080;
  localparam logic [15:0] MMD_UPPER_HI = 16'h00ff;
  localparam int MMD_BANK_COUNT = 4;
  localparam int MMD_BANK_REGS = 8;

  // ==========================================================
  // bit addressing layout
  localparam logic [7:0] MMD_BIT_SFR_MASK = 8'hf8;  // bit space above 0x7f hits sfr bytes
  localparam logic [7:0] MMD_BIT_SFR_START = 8'h80;

  // ==========================================================
  // snapshot result bank
  localparam int MMD_SNAP_CH = 16;
  localparam int MMD_SNAP_CW = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0] MMD_ADDR_RST = 16'h0000;
  localparam logic [7:0] MMD_BYTE_RST = 8'h00;

endpackage

/* design/mmd_snapshot.sv */
// snapshot bank: upper byte read freezes the matching lower byte
`timescale 1ns/1ps
`default_nettype none
module mmd_snapshot (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic rd_stb,
  input wire logic [5:0] rd_off,
  input wire logic [mmd_pkg::MMD_SNAP_CH*16-1:0] live_data,
  output logic [7:0] rd_data
);
  import mmd_pkg::*;

  typedef struct packed {
    logic [MMD_SNAP_CH-1:0][7:0] held;
  } mmd_snap_state_t;

  mmd_snap_state_t st;
  mmd_snap_state_t next_st;
  logic [MMD_SNAP_CW-1:0] ch;
  logic upper;

  // even offset is the upper byte of a channel, odd the lower
  assign ch = rd_off[MMD_SNAP_CW:1];
  assign upper = ~rd_off[0];

  // ==========================================================
  // capture and read path
  always_comb begin
    next_st = st;
    if (rd_stb && upper) begin
      next_st.held[ch] = live_data[ch*16 +: 8];  // freeze low half now
    end
    if (upper) begin
      rd_data = live_data[ch*16+8 +: 8];
    end else begin
      rd_data = st.held[ch];  // low half comes from the frozen copy
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

/* design/mmd_decoder.sv */
// memory map decoder: splits code, external and internal data accesses
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire mmd_pkg::mmd_space_t req_space,
  input wire logic req_indirect,
  input wire logic req_bit,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] store_rdata,
  input wire logic [mmd_pkg::MMD_SNAP_CH*16-1:0] adc_live,
  output mmd_pkg::mmd_region_t sel_region,
  output logic [15:0] sel_addr,
  output logic sel_rd,
  output logic sel_wr,
  output logic [7:0] sel_wdata,
  output logic sel_bit,
  output logic [2:0] sel_bit_idx,
  output logic [1:0] sel_bank,
  output logic resp_valid,
  output logic [7:0] resp_rdata
);
  import mmd_pkg::*;

  typedef struct packed {
    mmd_region_t region;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic bit_en;
    logic [2:0] bit_idx;
    logic [1:0] bank;
    logic resp_valid;
    logic [7:0] resp_rdata;
  } mmd_state_t;

  mmd_state_t st;
  mmd_state_t next_st;
  mmd_region_t dec_region;
  logic [15:0] dec_base;
  logic [15:0] eff_addr;
  logic [2:0] eff_bit;
  logic [7:0] snap_rdata;
  logic pend;
  logic next_pend;

  // ==========================================================
  // window test used by the code, external and internal data decode branches
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================
  // bit address to byte address translation
  always_comb begin
    eff_addr = req_addr;
    eff_bit = 3'h0;
    if (req_space == MMD_SP_IDATA && req_bit) begin
      eff_bit = req_addr[2:0];
      if (req_addr[7:0] < MMD_BIT_SFR_START) begin
        // bits 0x00..0x7f live in bytes 0x20..0x2f
        eff_addr = MMD_BITRAM_LO + {12'h000, req_addr[6:3]};
      end else begin
        // higher bit numbers hit sfr bytes on eight-byte rows
        eff_addr = {8'h00, req_addr[7:0] & MMD_BIT_SFR_MASK};
      end
    end
  end

  // ==========================================================
  // region decode per space
  always_comb begin
    dec_region = MMD_RG_NONE;
    dec_base = MMD_ADDR_RST;
    unique case (req_space)  // spaces never alias each other
      MMD_SP_CODE: begin
        if (in_win(eff_addr, MMD_VEC_LO, MMD_VEC_HI)) begin
          dec_region = MMD_RG_VECTOR;
        end else if (in_win(eff_addr, MMD_CTL_LO, MMD_CTL_HI)) begin
          dec_region = MMD_RG_CTRLBITS;
        end else if (in_win(eff_addr, MMD_CODE_LO, MMD_CODE_HI)) begin
          dec_region = MMD_RG_FLASH;
        end
        dec_base = MMD_CODE_LO;  // flash keeps the full code address
      end
      MMD_SP_XDATA: begin
        // narrow windows first, the can window sits inside the expansion ram span
        if (in_win(eff_addr, MMD_CAN_LO, MMD_CAN_HI)) begin
          dec_region = MMD_RG_CAN;
          dec_base = MMD_CAN_LO;
        end else if (in_win(eff_addr, MMD_MDU_LO, MMD_MDU_HI)) begin
          dec_region = MMD_RG_MDU;
          dec_base = MMD_MDU_LO;
        end else if (in_win(eff_addr, MMD_ADC_LO, MMD_ADC_HI)) begin
          dec_region = MMD_RG_ADC;
          dec_base = MMD_ADC_LO;
        end else if (in_win(eff_addr, MMD_EXPANSION_RAM_LO, MMD_EXPANSION_RAM_HI)) begin
          dec_region = MMD_RG_EXPANSION_RAM;
          dec_base = MMD_EXPANSION_RAM_LO;
        end else if (in_win(eff_addr, MMD_EXTENDED_FUNCTION_REGISTERS_LO, MMD_EXTENDED_FUNCTION_REGISTERS_HI)) begin
          dec_region = MMD_RG_EXTENDED_FUNCTION_REGISTERS;
          dec_base = MMD_EXTENDED_FUNCTION_REGISTERS_LO;
        end
      end
      MMD_SP_IDATA: begin
        if (eff_addr[15:8] != 8'h00) begin
          dec_region = MMD_RG_NONE;  // beyond the 256-byte space
        end else if (in_win(eff_addr, MMD_BANK_LO, MMD_BANK_HI)) begin
          dec_region = MMD_RG_BANK;
          dec_base = MMD_BANK_LO;
        end else if (in_win(eff_addr, MMD_INTERNAL_RAM_LO, MMD_INTERNAL_RAM_HI)) begin
          dec_region = MMD_RG_INTERNAL_RAM_LO;  // either mode reaches it
          dec_base = MMD_BANK_LO;
        end else if (in_win(eff_addr, MMD_UPPER_LO, MMD_UPPER_HI)) begin
          if (req_indirect && !req_bit) begin
            dec_region = MMD_RG_INTERNAL_RAM_HI;  // pointer access goes to ram
            dec_base = MMD_BANK_LO;
          end else begin
            dec_region = MMD_RG_SFR;  // direct access goes to registers
            dec_base = MMD_UPPER_LO;
          end
        end
      end
      MMD_SP_RSVD: begin
        dec_region = MMD_RG_NONE;
      end
    endcase
  end

  // ==========================================================
  // snapshot bank over the adc result window
  mmd_snapshot u_snap (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .rd_stb(st.rd && st.region == MMD_RG_ADC),
    .rd_off(st.addr[5:0]),
    .live_data(adc_live),
    .rd_data(snap_rdata)
  );

  // ==========================================================
  // stage one forwards strobes, stage two returns the answer
  always_comb begin
    next_st = st;
    next_st.rd = 1'b0;
    next_st.wr = 1'b0;
    next_st.resp_valid = 1'b0;
    next_st.resp_rdata = MMD_BYTE_RST;
    if (req_valid) begin
      next_st.region = dec_region;
      next_st.addr = eff_addr - dec_base;
      next_st.rd = !req_write && dec_region != MMD_RG_NONE;
      // code space and adc results are read-only, unmapped writes drop
      next_st.wr = req_write && dec_region != MMD_RG_NONE
                   && req_space != MMD_SP_CODE && dec_region != MMD_RG_ADC;
      next_st.wdata = req_wdata;
      next_st.bit_en = req_space == MMD_SP_IDATA && req_bit;
      next_st.bit_idx = eff_bit;
      next_st.bank = (dec_region == MMD_RG_BANK) ? eff_addr[4:3] : 2'h0;
    end
    // every taken request is answered, refused writes and unmapped ones too
    if (pend) begin
      next_st.resp_valid = 1'b1;
    end
    if (st.rd) begin
      if (st.region == MMD_RG_ADC) begin
        next_st.resp_rdata = snap_rdata;
      end else begin
        next_st.resp_rdata = store_rdata;
      end
    end
  end

  // ==========================================================
  // pending marker so refused and unmapped accesses still get an answer
  always_comb begin
    next_pend = req_valid;  // answered with zero when nothing was read
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pend <= 1'b0;
    end else if (clk_en) begin
      pend <= next_pend;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st.region <= MMD_RG_NONE;
      st.addr <= MMD_ADDR_RST;
      st.rd <= 1'b0;
      st.wr <= 1'b0;
      st.wdata <= MMD_BYTE_RST;
      st.bit_en <= 1'b0;
      st.bit_idx <= 3'h0;
      st.bank <= 2'h0;
      st.resp_valid <= 1'b0;
      st.resp_rdata <= MMD_BYTE_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from the state
  assign sel_region = st.region;
  assign sel_addr = st.addr;
  assign sel_rd = st.rd;
  assign sel_wr = st.wr;
  assign sel_wdata = st.wdata;
  assign sel_bit = st.bit_en;
  assign sel_bit_idx = st.bit_idx;
  assign sel_bank = st.bank;
  assign resp_valid = st.resp_valid;
  assign resp_rdata = st.resp_rdata;
endmodule
`default_nettype wire

/* dv/mmd_decoder_assertions.sv */
// concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire mmd_pkg::mmd_space_t req_space,
  input wire logic req_indirect,
  input wire logic req_bit,
  input wire logic [15:0] req_addr,
  input wire mmd_pkg::mmd_region_t sel_region,
  input wire logic [15:0] sel_addr,
  input wire logic sel_rd,
  input wire logic sel_wr,
  input wire logic [2:0] sel_bit_idx,
  input wire logic [1:0] sel_bank,
  input wire logic resp_valid
);
  import mmd_pkg::*;
  logic tk;
  logic idn;
  logic [15:0] ta;
  // taken request, internal byte access, last taken address
  assign tk = req_valid && clk_en;
  assign idn = tk && req_space == MMD_SP_IDATA && !req_bit;
  always_ff @(posedge core_clk) begin
    if (tk) begin
      ta <= req_addr;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_RESP_LAT: assert property (tk ##1 clk_en |-> ##1 resp_valid)
    else $error("request not answered two cycles later");
  AST_NO_STRAY: assert property (resp_valid && $past(clk_en) |-> $past(tk, 2))
    else $error("answer without a request");
  AST_VECTOR: assert property (tk && req_space == MMD_SP_CODE && req_addr < 16'h0100 |=> sel_region == MMD_RG_VECTOR)
    else $error("vector sector not decoded");
  AST_CTRL: assert property (tk && req_space == MMD_SP_CODE && req_addr[15:8] == 8'h7f |=> sel_region == MMD_RG_CTRLBITS)
    else $error("control bit sector not decoded");
  AST_EXTENDED_FUNCTION_REGISTERS: assert property (tk && req_space == MMD_SP_XDATA && req_addr >= 16'h4020 && req_addr <= 16'h40ff
    |=> sel_region == MMD_RG_EXTENDED_FUNCTION_REGISTERS && sel_addr == ta - 16'h4020)
    else $error("extended register window wrong");
  AST_BANK: assert property (idn && req_addr[7:5] == 3'h0 |=> sel_region == MMD_RG_BANK && sel_bank == ta[4:3])
    else $error("working register bank wrong");
  AST_SFR: assert property (idn && !req_indirect && req_addr[7] |=> sel_region == MMD_RG_SFR && sel_addr == {9'h000, ta[6:0]})
    else $error("direct upper access not routed to sfr");
  AST_IND: assert property (idn && req_indirect && req_addr[7] |=> sel_region == MMD_RG_INTERNAL_RAM_HI)
    else $error("pointer upper access not routed to ram");
  AST_BIT: assert property (tk && req_space == MMD_SP_IDATA && req_bit && !req_addr[7]
    |=> sel_region == MMD_RG_INTERNAL_RAM_LO && sel_addr == {12'h002, ta[6:3]} && sel_bit_idx == ta[2:0])
    else $error("bit number mapped to wrong byte");
  AST_NO_WR: assert property (sel_wr |-> !(sel_region inside {MMD_RG_NONE, MMD_RG_VECTOR, MMD_RG_FLASH, MMD_RG_CTRLBITS, MMD_RG_ADC}))
    else $error("write strobe to read only place");
  AST_RSVD: assert property (tk && req_space == MMD_SP_RSVD |=> sel_region == MMD_RG_NONE && !sel_rd && !sel_wr)
    else $error("reserved space decoded");
  // main scenarios reached
  cover property (sel_rd && sel_region == MMD_RG_ADC ##2 sel_rd && sel_region == MMD_RG_ADC);
  cover property (sel_region == MMD_RG_SFR && sel_bit_idx == 3'h3);
  cover property (sel_wr && sel_region == MMD_RG_EXTENDED_FUNCTION_REGISTERS);
endmodule
`default_nettype wire

/* dv/mmd_store_model.sv */
// storage behind the decoder: answers reads, idles with a moving pattern
`timescale 1ns/1ps
`default_nettype none
module mmd_store_model (
  input wire logic core_clk,
  input wire logic sel_rd,
  input wire logic [15:0] sel_addr,
  output logic [7:0] store_rdata
);
  logic [7:0] junk = 8'h00;
  // unselected bus never shows the last byte
  always @(posedge core_clk) junk <= junk + 8'h35;
  assign store_rdata = sel_rd ? (sel_addr[7:0] ^ 8'h3c) : junk;
endmodule
`default_nettype wire

/* dv/tb_memory_map_decoder.sv */
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_decoder;
  import mmd_pkg::*;
  logic core_clk, rstn, clk_en, req_valid, req_indirect, req_bit, req_write;
  mmd_space_t req_space;
  mmd_region_t sel_region;
  logic [15:0] req_addr, sel_addr, a;
  logic [7:0] req_wdata, store_rdata, sel_wdata, resp_rdata;
  logic [255:0] adc_live;
  logic sel_rd, sel_wr, sel_bit, resp_valid;
  logic [2:0] sel_bit_idx;
  logic [1:0] sel_bank;
  logic [31:0] r;
  logic [7:0] frz [16];
  logic [15:0] cor [16] = '{16'h0000, 16'h00ff, 16'h0100, 16'h40ff, 16'h7f00, 16'h7fff, 16'h0ef7,
    16'h0eab, 16'h0eac, 16'h4020, 16'h0ef8, 16'h0fd7, 16'h0fd8, 16'h0fff, 16'h401f, 16'h4100};
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 56;
  mmd_decoder dut (.core_clk, .rstn, .clk_en, .req_valid, .req_space, .req_indirect, .req_bit,
    .req_write, .req_addr, .req_wdata, .store_rdata, .adc_live, .sel_region, .sel_addr, .sel_rd,
    .sel_wr, .sel_wdata, .sel_bit, .sel_bit_idx, .sel_bank, .resp_valid, .resp_rdata);
  mmd_store_model u_mdl (.core_clk, .sel_rd, .sel_addr, .store_rdata);
  // ==========================================================
  // expected region and offset
  function automatic logic [19:0] exp_sel(logic [1:0] sp, logic ind, logic bt, logic [15:0] a);
    logic [7:0] by;
    by = a[7] ? {a[7:3], 3'h0} : {4'h2, a[6:3]};
    if (sp == 2'h0) return {a > 16'h7fff ? MMD_RG_NONE : a < 16'h0100 ? MMD_RG_VECTOR :
      a > 16'h7eff ? MMD_RG_CTRLBITS : MMD_RG_FLASH, a};
    if (sp == 2'h1) begin
      if (a >= 16'h0eac && a <= 16'h0ed7) return {MMD_RG_CAN, a - 16'h0eac};
      if (a >= 16'h0ef8 && a <= 16'h0fd7) return {MMD_RG_MDU, a - 16'h0ef8};
      if (a >= 16'h0fd8 && a <= 16'h0fff) return {MMD_RG_ADC, a - 16'h0fd8};
      if (a <= 16'h0ef7) return {MMD_RG_EXPANSION_RAM, a};
      if (a >= 16'h4020 && a <= 16'h40ff) return {MMD_RG_EXTENDED_FUNCTION_REGISTERS, a - 16'h4020};
      return {MMD_RG_NONE, a};
    end
    if (sp != 2'h2) return {MMD_RG_NONE, a};
    if (bt) return {a[7] ? MMD_RG_SFR : MMD_RG_INTERNAL_RAM_LO, 8'h00, by ^ {a[7], 7'h00}};
    if (a < 16'h0020) return {MMD_RG_BANK, a};
    if (a < 16'h0080) return {MMD_RG_INTERNAL_RAM_LO, a};
    return ind ? {MMD_RG_INTERNAL_RAM_HI, a} : {MMD_RG_SFR, a - 16'h0080};
  endfunction
  task automatic chk(string n, logic [15:0] x, logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // one access: request, decoded strobes, answer
  task automatic acc(logic [1:0] sp, logic ind, logic bt, logic wr, logic [15:0] a, logic [7:0] wd);
    logic [19:0] e;
    logic [7:0] er;
    logic m;
    e = exp_sel(sp, ind, bt, a);
    m = e[19:16] != MMD_RG_NONE;
    er = 8'h00;
    if (!wr && e[19:16] == MMD_RG_ADC) begin
      er = e[0] ? frz[e[4:1]] : adc_live[e[4:1] * 16 + 8 +: 8];
      if (!e[0]) frz[e[4:1]] = adc_live[e[4:1] * 16 +: 8];
    end else if (!wr && m) er = e[7:0] ^ 8'h3c;
    req_valid = 1;
    req_space = mmd_space_t'(sp);
    req_indirect = ind;
    req_bit = bt;
    req_write = wr;
    req_addr = a;
    req_wdata = wd;
    @(posedge core_clk) #1;
    req_valid = 0;
    chk("region", e[19:16], sel_region);
    if (m) chk("offset", e[15:0], sel_addr);
    chk("rd", !wr && m, sel_rd);
    chk("wr", wr && m && e[19:16] > MMD_RG_CTRLBITS && e[19:16] != MMD_RG_ADC, sel_wr);
    if (wr) chk("wdata", wd, sel_wdata);
    if (bt) chk("bitidx", a[2:0], sel_bit_idx);
    chk("bit", sp == 2'h2 && bt, sel_bit);
    if (e[19:16] == MMD_RG_BANK) chk("bank", a[4:3], sel_bank);
    @(posedge core_clk) #1;
    chk("resp", 1'b1, resp_valid);
    chk("rdata", er, resp_rdata);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    finish_test;
  end
  // ==========================================================
  // corner cases, then random traffic
  initial begin
    {rstn, req_valid, req_indirect, req_bit, req_write, req_addr, req_wdata, adc_live} = '0;
    clk_en = 1;
    req_space = MMD_SP_CODE;
    foreach (frz[i]) frz[i] = 8'h00;
    repeat (12) @(posedge core_clk);
    #1 rstn = 1;
    adc_live[15:0] = 16'h1234;
    adc_live[255:240] = 16'hbeef;
    acc(2'h1, 0, 0, 0, 16'h0fd8, 8'h00);
    adc_live[15:0] = 16'h56ab;
    acc(2'h1, 0, 0, 0, 16'h0fd9, 8'h00);
    acc(2'h1, 0, 0, 0, 16'h0ff6, 8'h00);
    adc_live[255:240] = 16'h0000;
    acc(2'h1, 0, 0, 0, 16'h0ff7, 8'h00);
    acc(2'h0, 0, 0, 1, 16'h0010, 8'h5a);
    acc(2'h1, 0, 0, 1, 16'h0fd8, 8'h5a);
    acc(2'h2, 0, 0, 0, 16'h0090, 8'h00);
    acc(2'h2, 1, 0, 0, 16'h0090, 8'h00);
    acc(2'h2, 0, 1, 0, 16'h000b, 8'h00);
    acc(2'h2, 0, 1, 1, 16'h008b, 8'h01);
    acc(2'h3, 0, 0, 1, 16'h0010, 8'h77);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (r[12:10] == 3'h0) begin
        clk_en = 0;
        @(posedge core_clk) #1;
        clk_en = 1;
      end
      if (r[13]) adc_live[r[17:14] * 16 +: 16] = r[31:16];
      a = r[1:0] == 2'h2 ? {8'h00, r[31:24]} : r[5] ? cor[r[9:6]] : r[31:16];
      acc(r[1:0], r[2], r[3] && r[1:0] == 2'h2, r[4], a, r[23:16]);
    end
    finish_test;
  end
endmodule
bind mmd_decoder mmd_decoder_assertions u_chk (.core_clk, .rstn, .clk_en, .req_valid, .req_space,
  .req_indirect, .req_bit, .req_addr, .sel_region, .sel_addr, .sel_rd, .sel_wr, .sel_bit_idx,
  .sel_bank, .resp_valid);
`default_nettype wire
